// File: smbmr_params.svh
`ifndef SMBMR_PARAMS_SVH
`define SMBMR_PARAMS_SVH
`define SMBMR_CLK_PERIOD_NS 25
`define SMBMR_SCL_HALF_NS 100
`define SMBMR_HALF_CYC ((`SMBMR_SCL_HALF_NS + `SMBMR_CLK_PERIOD_NS - 1) / `SMBMR_CLK_PERIOD_NS)
`define SMBMR_OFS_CTRL 3'h0
`define SMBMR_OFS_STATUS 3'h1
`define SMBMR_OFS_DATA 3'h2
`define SMBMR_OFS_ADDR 3'h3
`define SMBMR_OFS_INT 3'h4
`define SMBMR_OFS_MASK 3'h5
`define SMBMR_CTRL_START 0
`define SMBMR_CTRL_STOP 1
`define SMBMR_CTRL_ACK 2
`define SMBMR_CTRL_HWACK 3
`define SMBMR_ST_ACK_REQUEST_FLAG 0
`define SMBMR_ST_BUSY 1
`define SMBMR_ST_MRX 2
`define SMBMR_ST_MTX 3
`define SMBMR_ST_SLVACK 4
`define SMBMR_INT_BYTE 0
`define SMBMR_INT_STOP 1
`define SMBMR_INT_NACK 2
`define SMBMR_ADDR_RST 7'h00
`define SMBMR_MASK_RST 3'h0
`define SMBMR_DATA_RST 8'h00
`endif

// File: smbmr_pkg.sv
package smbmr_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_ACKREQ,
    ST_HOLD, ST_STOP_LOW, ST_STOP_HIGH, ST_STOP_END
  } smbmr_state_t;
  typedef enum logic [1:0] {K_ADDR, K_TX, K_RX} smbmr_kind_t;
  typedef struct packed {
    logic hw_ack;
    logic ack;
    logic stop;
  } smbmr_ctrl_t;
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } smbmr_pins_t;
endpackage

// File: smbmr_master_rx.sv
// Notes on behaviour
// - START, then address byte with read bit
// - Transmit address, and data after a switch to transmit; receive data, drive SCL
// - Manual ack: flag and interrupt before ack
// - Auto ack: send ack, then interrupt
// - Ack bit one acks, zero nacks
// - Leave receiver only after STOP request or on switch to transmit
// - Data write while receiving switches to transmit
// - Unlimited bytes until nack and STOP
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "smbmr_params.svh"
module smbmr_master_rx #(
  parameter int HALF_CYC = `SMBMR_HALF_CYC,
  parameter int CNT_W    = 8
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic [2:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [7:0]                 reg_rdata,
  output logic                       irq,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output smbmr_pkg::smbmr_pins_t     pins
);
  import smbmr_pkg::*;

  localparam logic [CNT_W-1:0] RELOAD = CNT_W'(HALF_CYC - 1);

  smbmr_state_t      state_q, state_d;
  smbmr_kind_t       kind_q, kind_d;
  smbmr_ctrl_t       ctrl_q, ctrl_d;
  smbmr_pins_t       pins_q, pins_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [3:0]        bit_q, bit_d;
  logic [7:0]        sh_q, sh_d;
  logic [7:0]        rx_q, rx_d;
  logic [7:0]        dat_q, dat_d;
  logic [6:0]        addr_q, addr_d;
  logic [2:0]        int_q, int_d;
  logic [2:0]        mask_q, mask_d;
  logic [7:0]        rdata_q, rdata_d;
  logic              pend_q, pend_d;
  logic              ack_request_flag_q, ack_request_flag_d;
  logic              mrx_q, mrx_d;
  logic              mtx_q, mtx_d;
  logic              go_q, go_d;
  logic              slv_ack_q, slv_ack_d;
  logic [1:0][2:0]   sync_q, sync_d;
  logic [1:0]        filt_q, filt_d;
  logic [2:0]        ev;
  logic              cnt_zero;
  logic              scl_f;
  logic              sda_f;
  logic              scl_drv;
  logic              sda_drv;
  logic              wr_ctrl;
  logic              wr_data;
  logic              rd_int;

  assign wr_ctrl   = reg_wr && (reg_addr == `SMBMR_OFS_CTRL);
  assign wr_data   = reg_wr && (reg_addr == `SMBMR_OFS_DATA);
  assign rd_int    = reg_rd && (reg_addr == `SMBMR_OFS_INT);
  assign scl_f     = filt_q[1];
  assign sda_f     = filt_q[0];
  assign cnt_zero  = (cnt_q == '0);
  assign reg_rdata = rdata_q;
  assign pins      = pins_q;
  assign irq       = |(int_q & mask_q);

  // Stage 0 feeds only stage 1; a level counts once stages 1 and 2 agree
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sync_d[i] = {sync_q[i][1:0], (i == 1) ? scl_i : sda_i};
      filt_d[i] = (sync_q[i][1] == sync_q[i][2]) ? sync_q[i][2] : filt_q[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_q <= {2{3'h7}};
      filt_q <= 2'h3;
    end else begin
      sync_q <= sync_d;
      filt_q <= filt_d;
    end
  end

  always_comb begin
    state_d   = state_q;
    kind_d    = kind_q;
    ctrl_d    = ctrl_q;
    cnt_d     = cnt_q;
    bit_d     = bit_q;
    sh_d      = sh_q;
    rx_d      = rx_q;
    dat_d     = dat_q;
    addr_d    = addr_q;
    mask_d    = mask_q;
    pend_d    = pend_q;
    ack_request_flag_d   = ack_request_flag_q;
    mrx_d     = mrx_q;
    mtx_d     = mtx_q;
    go_d      = go_q;
    slv_ack_d = slv_ack_q;
    ev        = 3'h0;
    rdata_d   = 8'h00;
    unique case (state_q)
      ST_IDLE: begin
        if (wr_ctrl && reg_wdata[`SMBMR_CTRL_START]) begin
          state_d = ST_START;
          kind_d  = K_ADDR;
          sh_d    = {addr_q, 1'b1};
          cnt_d   = RELOAD;
        end
      end
      ST_START: begin
        if (cnt_zero) begin
          state_d = ST_LOW;
          bit_d   = 4'h0;
          cnt_d   = RELOAD;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_LOW: begin
        if (cnt_zero) begin
          state_d = ST_HIGH;
          cnt_d   = RELOAD;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_HIGH: begin
        // A slave that stretches SCL freezes the high-phase count
        if (scl_f && !cnt_zero) begin
          cnt_d = cnt_q - 1'b1;
        end else if (scl_f && bit_q != 4'h8) begin
          sh_d  = {sh_q[6:0], sda_f};
          cnt_d = RELOAD;
          if (bit_q == 4'h7 && kind_q == K_RX) begin
            rx_d = {sh_q[6:0], sda_f};
            if (!ctrl_q.hw_ack) begin
              state_d = ST_ACKREQ;
              ack_request_flag_d = 1'b1;
              ev[`SMBMR_INT_BYTE] = 1'b1;
            end else begin
              state_d = ST_LOW;
              bit_d   = 4'h8;
            end
          end else begin
            state_d = ST_LOW;
            bit_d   = bit_q + 4'h1;
          end
        end else if (scl_f) begin
          state_d = ST_HOLD;
          if (kind_q == K_RX) begin
            go_d = ctrl_q.ack;
            if (ctrl_q.hw_ack) begin
              ev[`SMBMR_INT_BYTE] = 1'b1;
            end
          end else begin
            slv_ack_d = !sda_f;
            go_d      = !sda_f;
            ev[`SMBMR_INT_BYTE] = 1'b1;
            ev[`SMBMR_INT_NACK] = sda_f;
            if (kind_q == K_ADDR) begin
              mrx_d = 1'b1;
            end
          end
        end
      end
      ST_ACKREQ: begin
        if (wr_ctrl) begin
          ack_request_flag_d = 1'b0;
          state_d = ST_LOW;
          bit_d   = 4'h8;
          cnt_d   = RELOAD;
        end
      end
      ST_HOLD: begin
        cnt_d = RELOAD;
        if (ctrl_q.stop) begin
          state_d = ST_STOP_LOW;
        end else if (pend_q) begin
          pend_d  = 1'b0;
          sh_d    = dat_q;
          kind_d  = K_TX;
          mrx_d   = 1'b0;
          mtx_d   = 1'b1;
          state_d = ST_LOW;
          bit_d   = 4'h0;
        end else if (mrx_q && go_q && !int_q[`SMBMR_INT_BYTE]) begin
          kind_d  = K_RX;
          state_d = ST_LOW;
          bit_d   = 4'h0;
        end
      end
      ST_STOP_LOW: begin
        if (cnt_zero) begin
          state_d = ST_STOP_HIGH;
          cnt_d   = RELOAD;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_STOP_HIGH: begin
        if (scl_f && cnt_zero) begin
          state_d = ST_STOP_END;
          cnt_d   = RELOAD;
        end else if (scl_f) begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_STOP_END: begin
        if (cnt_zero) begin
          state_d     = ST_IDLE;
          ctrl_d.stop = 1'b0;
          mrx_d       = 1'b0;
          mtx_d       = 1'b0;
          go_d        = 1'b0;
          pend_d      = 1'b0;
          ev[`SMBMR_INT_STOP] = 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
    endcase
    // Register writes come last so a write in a consuming cycle is kept
    if (reg_wr) begin
      unique case (reg_addr)
        `SMBMR_OFS_CTRL: begin
          ctrl_d.ack    = reg_wdata[`SMBMR_CTRL_ACK];
          ctrl_d.hw_ack = reg_wdata[`SMBMR_CTRL_HWACK];
          if (reg_wdata[`SMBMR_CTRL_STOP]) begin
            ctrl_d.stop = 1'b1;
          end
        end
        `SMBMR_OFS_DATA: begin
          dat_d = reg_wdata;
          if (mrx_d || mtx_d) begin
            pend_d = 1'b1;
          end
        end
        `SMBMR_OFS_ADDR: addr_d = reg_wdata[6:0];
        `SMBMR_OFS_MASK: mask_d = reg_wdata[2:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `SMBMR_OFS_CTRL: begin
          rdata_d[`SMBMR_CTRL_STOP]  = ctrl_q.stop;
          rdata_d[`SMBMR_CTRL_ACK]   = ctrl_q.ack;
          rdata_d[`SMBMR_CTRL_HWACK] = ctrl_q.hw_ack;
        end
        `SMBMR_OFS_STATUS: begin
          rdata_d[`SMBMR_ST_ACK_REQUEST_FLAG]  = ack_request_flag_q;
          rdata_d[`SMBMR_ST_BUSY]   = (state_q != ST_IDLE);
          rdata_d[`SMBMR_ST_MRX]    = mrx_q;
          rdata_d[`SMBMR_ST_MTX]    = mtx_q;
          rdata_d[`SMBMR_ST_SLVACK] = slv_ack_q;
        end
        `SMBMR_OFS_DATA: rdata_d = rx_q;
        `SMBMR_OFS_ADDR: rdata_d = {1'b0, addr_q};
        `SMBMR_OFS_INT:  rdata_d = {5'h00, int_q};
        `SMBMR_OFS_MASK: rdata_d = {5'h00, mask_q};
        default: ;
      endcase
    end
    // A new event wins over the read that clears the bits
    int_d = (rd_int ? 3'h0 : int_q) | ev;
    scl_drv = state_d inside {ST_LOW, ST_ACKREQ, ST_HOLD, ST_STOP_LOW};
    unique case (state_d)
      ST_START, ST_STOP_LOW, ST_STOP_HIGH: sda_drv = 1'b1;
      ST_LOW, ST_HIGH: begin
        if (kind_d == K_RX) begin
          sda_drv = (bit_d == 4'h8) && ctrl_d.ack;
        end else begin
          sda_drv = (bit_d != 4'h8) && !sh_d[7];
        end
      end
      default: sda_drv = 1'b0;
    endcase
    // SDA stays put on the edge where SCL falls, giving the slave hold time
    pins_d.sda_oe = (scl_drv && !pins_q.scl_oe) ? pins_q.sda_oe : sda_drv;
    pins_d.scl_oe = scl_drv;
    pins_d.scl_o  = 1'b0;
    pins_d.sda_o  = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      kind_q    <= K_ADDR;
      ctrl_q    <= '0;
      pins_q    <= '0;
      cnt_q     <= '0;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      rx_q      <= `SMBMR_DATA_RST;
      dat_q     <= `SMBMR_DATA_RST;
      addr_q    <= `SMBMR_ADDR_RST;
      int_q     <= 3'h0;
      mask_q    <= `SMBMR_MASK_RST;
      rdata_q   <= 8'h00;
      pend_q    <= 1'b0;
      ack_request_flag_q   <= 1'b0;
      mrx_q     <= 1'b0;
      mtx_q     <= 1'b0;
      go_q      <= 1'b0;
      slv_ack_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      kind_q    <= kind_d;
      ctrl_q    <= ctrl_d;
      pins_q    <= pins_d;
      cnt_q     <= cnt_d;
      bit_q     <= bit_d;
      sh_q      <= sh_d;
      rx_q      <= rx_d;
      dat_q     <= dat_d;
      addr_q    <= addr_d;
      int_q     <= int_d;
      mask_q    <= mask_d;
      rdata_q   <= rdata_d;
      pend_q    <= pend_d;
      ack_request_flag_q   <= ack_request_flag_d;
      mrx_q     <= mrx_d;
      mtx_q     <= mtx_d;
      go_q      <= go_d;
      slv_ack_q <= slv_ack_d;
    end
  end

  property p_start_addr;
    @(posedge clk_sys) disable iff (rst)
    (state_q == ST_START && state_d == ST_LOW)
      |=> (kind_q == K_ADDR && sh_q[0] && bit_q == 4'h0 && pins_q.scl_oe);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("address byte lacks read bit");

  property p_rx_release;
    @(posedge clk_sys) disable iff (rst)
    (state_q == ST_HIGH && kind_q == K_RX && bit_q < 4'h8) |-> !pins_q.sda_oe;
  endproperty
  a_rx_release: assert property (p_rx_release) else $error("SDA driven during data bit");

  property p_manual_req;
    @(posedge clk_sys) disable iff (rst)
    (state_q == ST_HIGH && state_d == ST_ACKREQ)
      |=> (ack_request_flag_q && int_q[`SMBMR_INT_BYTE] && !pins_q.sda_oe) [*2];
  endproperty
  a_manual_req: assert property (p_manual_req) else $error("ack request not raised before ack");

  property p_auto_order;
    @(posedge clk_sys) disable iff (rst)
    (state_q == ST_HIGH && kind_q == K_RX && bit_q == 4'h7 && state_d == ST_LOW && ctrl_q.hw_ack && !int_q[0])
      |=> !int_q[`SMBMR_INT_BYTE] until_with (state_q == ST_HIGH && bit_q == 4'h8);
  endproperty
  a_auto_order: assert property (p_auto_order) else $error("interrupt before auto ack");

  property p_ack_level;
    @(posedge clk_sys) disable iff (rst)
    (state_q == ST_HIGH && kind_q == K_RX && bit_q == 4'h8) |-> (pins_q.sda_oe == ctrl_q.ack);
  endproperty
  a_ack_level: assert property (p_ack_level) else $error("ack bit does not follow control");

  property p_leave_rx;
    @(posedge clk_sys) disable iff (rst)
    $fell(mrx_q) |-> ($past(state_q) == ST_STOP_END || mtx_q);
  endproperty
  a_leave_rx: assert property (p_leave_rx) else $error("left receiver without STOP");

  property p_to_tx;
    @(posedge clk_sys) disable iff (rst)
    (wr_data && mrx_q && state_q == ST_HOLD && !ctrl_q.stop && !reg_wdata[1]) |-> ##2 (mtx_q && !mrx_q);
  endproperty
  a_to_tx: assert property (p_to_tx) else $error("no switch to transmitter");

  property p_next_byte;
    @(posedge clk_sys) disable iff (rst)
    (state_q == ST_HOLD && mrx_q && go_q && !int_q[0] && !ctrl_q.stop && !pend_q)
      |=> (state_q == ST_LOW && bit_q == 4'h0 && kind_q == K_RX);
  endproperty
  a_next_byte: assert property (p_next_byte) else $error("next byte did not start");

  property p_stretch;
    @(posedge clk_sys) disable iff (rst)
    (state_q == ST_HOLD && int_q[`SMBMR_INT_BYTE] && !ctrl_q.stop && !pend_q) |=> pins_q.scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("SCL released while interrupt pending");

  c_manual: cover property (@(posedge clk_sys) disable iff (rst) state_q == ST_ACKREQ ##1 state_q == ST_LOW);
  c_auto: cover property (@(posedge clk_sys) disable iff (rst) kind_q == K_RX && ctrl_q.hw_ack && ev[0]);
  c_stop: cover property (@(posedge clk_sys) disable iff (rst) ev[`SMBMR_INT_STOP]);
  c_to_tx: cover property (@(posedge clk_sys) disable iff (rst) $rose(mtx_q));
endmodule // smbmr_master_rx
`default_nettype wire

// File: smbmr_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module smbmr_slave_model #(
  parameter logic [6:0]  ADDR  = 7'h2C,
  parameter logic [31:0] BYTES = 32'h5AC3_3CA5
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       slow,
  input  wire logic [3:0] n_max,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic [7:0]      addr_rx,
  output logic [7:0]      n_mack,
  output logic            last_mack
);
  int   n_fall;
  int   n_rise;
  int   n_byte;
  logic active;
  logic send;
  initial begin
    {scl_oe, sda_oe, active, send, last_mack} = 5'h00;
    {addr_rx, n_mack} = 16'h0000;
  end
  // Start: SDA falls while SCL is high
  always @(negedge sda) if (scl) begin
    {active, send, last_mack} = 3'b110;
    n_mack = 8'h00;
    n_fall = 0;
    n_rise = 0;
    n_byte = 0;
  end
  always @(posedge sda) if (scl) begin
    active = 1'b0;
    sda_oe = 1'b0;
  end
  always @(posedge scl) if (active) begin
    n_rise++;
    if (n_rise <= 8) addr_rx = {addr_rx[6:0], sda};
    else if (n_rise >= 10 && (n_rise - 10) % 9 == 8) begin
      n_mack++;
      last_mack = !sda;
      // A refused byte ends our sending; otherwise bytes keep coming until n_max bytes are sent
      if (sda) send = 1'b0;
    end
  end
  always @(negedge scl) if (active) begin
    int pos;
    n_fall++;
    pos = (n_fall - 10) % 9;
    // A slave that was not addressed leaves SDA released for the rest of the frame
    if (n_fall == 9) begin
      sda_oe = (addr_rx == {ADDR, 1'b1});
      send   = sda_oe;
    end
    else if (n_fall >= 10 && pos < 8 && send && n_byte < n_max) sda_oe = !BYTES[8*(n_byte%4)+7-pos];
    else sda_oe = 1'b0;
    if (n_fall >= 10 && pos == 7) n_byte++;
    // Slow mode stretches every low phase to test the master's wait
    if (slow) begin
      scl_oe = 1'b1;
      #300 scl_oe = 1'b0;
    end
  end
endmodule  // smbmr_slave_model
`default_nettype wire

// File: smbmr_master_rx_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "smbmr_params.svh"
module smbmr_master_rx_tb;
  import smbmr_pkg::*;
  localparam logic [31:0] BYTES = 32'h5AC3_3CA5;
  localparam logic [7:0]  C_GO  = 8'h01 << `SMBMR_CTRL_START;
  localparam logic [7:0]  C_STP = 8'h01 << `SMBMR_CTRL_STOP;
  localparam logic [7:0]  C_ACK = 8'h01 << `SMBMR_CTRL_ACK;
  localparam logic [7:0]  C_HW  = 8'h01 << `SMBMR_CTRL_HWACK;
  localparam logic [7:0]  S_RQ  = 8'h01 << `SMBMR_ST_ACK_REQUEST_FLAG;
  localparam logic [7:0]  S_BSY = 8'h01 << `SMBMR_ST_BUSY;
  localparam logic [7:0]  S_RX  = 8'h01 << `SMBMR_ST_MRX;
  localparam logic [7:0]  S_TX  = 8'h01 << `SMBMR_ST_MTX;
  localparam logic [7:0]  S_SAK = 8'h01 << `SMBMR_ST_SLVACK;
  logic        clk_sys   = 1'b0;
  logic        rst       = 1'b1;
  logic [2:0]  reg_addr  = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_rdata;
  logic        irq;
  smbmr_pins_t pins;
  logic        slow      = 1'b0;
  logic [3:0]  n_max     = 4'h4;
  logic        s_scl_oe;
  logic        s_sda_oe;
  logic        last_mack;
  logic [7:0]  addr_rx;
  logic [7:0]  n_mack;
  wire         scl_w;
  wire         sda_w;
  int          n_mismatch = 0;
  int          checks     = 0;
  // Pulled-up open-drain lines: low while any party pulls
  assign scl_w = !(pins.scl_oe || s_scl_oe);
  assign sda_w = !(pins.sda_oe || s_sda_oe);
  always #12.5 clk_sys = !clk_sys;
  smbmr_master_rx i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .scl_i(scl_w), .sda_i(sda_w),
    .pins(pins));
  smbmr_slave_model i_slave (.scl(scl_w), .sda(sda_w), .slow(slow), .n_max(n_max), .scl_oe(s_scl_oe),
    .sda_oe(s_sda_oe), .addr_rx(addr_rx), .n_mack(n_mack), .last_mack(last_mack));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v & m, e);
  endtask
  task automatic poll(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    v = ~e;
    for (int i = 0; i < 500 && (v & m) !== e; i++) rd(a, v);
    chk(v & m, e);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clk_sys);
    chk({7'h00, irq}, 8'h01);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rdchk(3'(a), 8'hFF, 8'h00);
    wr(3'h6, 8'hFF);
    rdchk(3'h6, 8'hFF, 8'h00);
    chk({4'h0, pins}, 8'h00);
    $display("test reset done");
    wr(`SMBMR_OFS_ADDR, 8'h2C);
    wr(`SMBMR_OFS_MASK, 8'h07);
    wr(`SMBMR_OFS_CTRL, C_GO | C_ACK);
    wait_irq();
    chk(addr_rx, 8'h59);
    rdchk(`SMBMR_OFS_STATUS, S_SAK | S_RX, S_SAK | S_RX);
    rdchk(`SMBMR_OFS_INT, 8'h01, 8'h01);
    for (int k = 0; k < 2; k++) begin
      wait_irq();
      rdchk(`SMBMR_OFS_STATUS, S_RQ, S_RQ);
      chk(n_mack, 8'(k));
      chk({7'h00, last_mack}, 8'(k));
      repeat (40) @(posedge clk_sys);
      chk({7'h00, pins.scl_oe}, 8'h01);
      rdchk(`SMBMR_OFS_DATA, 8'hFF, BYTES[8*k+:8]);
      wr(`SMBMR_OFS_CTRL, k == 0 ? C_ACK : 8'h00);
      rdchk(`SMBMR_OFS_INT, 8'h01, 8'h01);
    end
    rdchk(`SMBMR_OFS_STATUS, S_RX, S_RX);
    wr(`SMBMR_OFS_CTRL, C_STP);
    wait_irq();
    rdchk(`SMBMR_OFS_INT, 8'h02, 8'h02);
    chk(n_mack, 8'h02);
    chk({7'h00, last_mack}, 8'h00);
    rdchk(`SMBMR_OFS_STATUS, S_RX | S_BSY, 8'h00);
    $display("test manual ack done");
    slow <= 1'b1;
    wr(`SMBMR_OFS_CTRL, C_GO | C_HW | C_ACK);
    wait_irq();
    rdchk(`SMBMR_OFS_INT, 8'h01, 8'h01);
    for (int k = 0; k < 3; k++) begin
      wait_irq();
      chk(n_mack, 8'(k + 1));
      chk({7'h00, last_mack}, k < 2 ? 8'h01 : 8'h00);
      rdchk(`SMBMR_OFS_STATUS, S_RQ, 8'h00);
      rdchk(`SMBMR_OFS_DATA, 8'hFF, BYTES[8*k+:8]);
      if (k == 1) wr(`SMBMR_OFS_CTRL, C_HW);
      rdchk(`SMBMR_OFS_INT, 8'h01, 8'h01);
    end
    wr(`SMBMR_OFS_MASK, 8'h00);
    wr(`SMBMR_OFS_CTRL, C_HW | C_STP);
    poll(`SMBMR_OFS_STATUS, S_BSY | S_RX, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(`SMBMR_OFS_MASK, 8'h07);
    #1 chk({7'h00, irq}, 8'h01);
    rdchk(`SMBMR_OFS_INT, 8'h02, 8'h02);
    #1 chk({7'h00, irq}, 8'h00);
    $display("test auto ack done");
    slow <= 1'b0;
    n_max <= 4'h1;
    wr(`SMBMR_OFS_CTRL, C_GO | C_HW | C_ACK);
    wait_irq();
    rdchk(`SMBMR_OFS_INT, 8'h01, 8'h01);
    wait_irq();
    wr(`SMBMR_OFS_DATA, 8'h96);
    rdchk(`SMBMR_OFS_STATUS, S_TX | S_RX, S_TX);
    rdchk(`SMBMR_OFS_INT, 8'h01, 8'h01);
    wr(`SMBMR_OFS_CTRL, C_HW | C_STP);
    poll(`SMBMR_OFS_STATUS, S_BSY, 8'h00);
    rdchk(`SMBMR_OFS_INT, 8'h07, 8'h07);
    chk(n_mack, 8'h02);
    $display("test switch to transmit done");
    wr(`SMBMR_OFS_ADDR, 8'h2D);
    wr(`SMBMR_OFS_CTRL, C_GO | C_HW);
    wait_irq();
    chk(addr_rx, 8'h5B);
    rdchk(`SMBMR_OFS_INT, 8'h05, 8'h05);
    rdchk(`SMBMR_OFS_STATUS, S_SAK | S_RX, S_RX);
    wr(`SMBMR_OFS_CTRL, C_STP);
    poll(`SMBMR_OFS_STATUS, S_BSY | S_RX, 8'h00);
    $display("test address refused done");
    end_of_test();
  end
endmodule  // smbmr_master_rx_tb
`default_nettype wire
